// >>> ingress_acl_filter.sv
// Ingress access filter: DSCP map enables, rule groups and source address cap.
`default_nettype none
module ingress_acl_filter #(
  parameter int SLOTS = ingress_acl_filter_pkg::ADDR_SLOTS,
  parameter logic [31:0] AGE_CYCLES = 32'(ingress_acl_filter_pkg::AGE_SECONDS *
    ingress_acl_filter_pkg::CLK_HZ)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // AHB-Lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Parsed frame from the ingress port logic
  input wire logic frmValid,
  input wire logic [4:0] frmPort,
  input wire logic [11:0] frmVlan,
  input wire logic frmIpv4,
  input wire logic [15:0] frmEtherType,
  input wire logic [31:0] frmSrcIp,
  input wire logic [31:0] frmDstIp,
  input wire logic frmFrag,
  input wire logic [7:0] frmProto,
  input wire logic [15:0] frmL4Port,
  input wire logic [47:0] frmSrcMac,
  output logic frmReady,
  // Verdict
  output logic verdictValid,
  output logic verdictPass,
  output logic verdictMapDscp
);
  localparam int SW = $clog2(SLOTS);
  localparam int GC = ingress_acl_filter_pkg::GROUP_COUNT;
  localparam int PC = ingress_acl_filter_pkg::PORT_COUNT;

  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic wrPend;
    logic [7:0] wrAddr;
    logic bindEn;
    logic limitEn;
    logic [PC-1:0] dscpEn;
    logic [6:0] cap;
    logic [7:0] ruleGroupIndex;
    ingress_acl_filter_pkg::rule_entry_type stage;
    logic [GC:1] ruleValid;
    ingress_acl_filter_pkg::state_type st;
    logic [7:0] scanIdx;
    logic aclHit;
    logic aclDeny;
    logic [4:0] port;
    logic [11:0] vlan;
    logic ipv4;
    logic [15:0] etherType;
    logic [31:0] srcIp;
    logic [31:0] dstIp;
    logic frag;
    logic [7:0] proto;
    logic [15:0] l4Port;
    logic [47:0] srcMac;
    logic [SLOTS-1:0] macValid;
    logic [SLOTS-1:0] macHit;
    logic [31:0] ageCnt;
    logic [15:0] blockedCount;
    logic macBlocked;
    logic frmReady;
    logic verdictValid;
    logic verdictPass;
    logic verdictMapDscp;
  } filter_state_type;

  filter_state_type s;
  filter_state_type next_s;
  ingress_acl_filter_pkg::rule_entry_type ruleMem [1:GC];
  logic [47:0] macMem [SLOTS];
  ingress_acl_filter_pkg::rule_entry_type entry;
  logic ruleWr;
  logic [7:0] ruleWrIdx;
  logic macWr;
  logic [SW-1:0] macWrIdx;
  logic hitNow;
  logic found;
  logic [SW-1:0] foundIdx;
  logic haveFree;
  logic [SW-1:0] freeIdx;
  logic [7:0] learned;
  logic capOn;

  // ******************************************************************
  // Matching helpers
  // ******************************************************************
  function automatic logic addrOk(input logic any, input logic [31:0] pkt,
                                  input logic [31:0] rule, input logic [31:0] mask);
    addrOk = any || (((pkt ^ rule) & mask) == 32'h00000000);
  endfunction

  function automatic logic ruleMatch(input ingress_acl_filter_pkg::rule_entry_type e,
                                     input filter_state_type f);
    logic vlanOk;
    vlanOk = e.vlanAny || (e.vid == f.vlan);
    unique case (e.kind)
      ingress_acl_filter_pkg::KIND_IPV4: begin
        ruleMatch = f.ipv4 && vlanOk && addrOk(e.srcAny, f.srcIp, e.srcIp, e.srcMask) &&
          addrOk(e.dstAny, f.dstIp, e.dstIp, e.dstMask) &&
          (!e.fragChk || (f.frag == e.fragVal)) &&
          (e.protoAny || (f.proto == e.proto)) &&
          (e.valueAny || (f.l4Port == e.value)) &&
          ((e.portSel == 5'h00) || (e.portSel == f.port));
      end
      ingress_acl_filter_pkg::KIND_NON_IPV4: begin
        ruleMatch = !f.ipv4 && vlanOk && (e.valueAny || (f.etherType == e.value));
      end
      ingress_acl_filter_pkg::KIND_BINDING: begin
        ruleMatch = f.bindEn && (f.srcIp == e.srcIp) && (f.srcMac == e.mac) &&
          (f.vlan == e.vid) && (f.port == e.bindPort);
      end
      default: begin
        ruleMatch = 1'b0;
      end
    endcase
  endfunction

  // ******************************************************************
  // Address table lookup
  // ******************************************************************
  always_comb begin
    found = 1'b0;
    foundIdx = '0;
    haveFree = 1'b0;
    freeIdx = '0;
    learned = 8'h00;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (s.macValid[i] && (macMem[i] == s.srcMac)) begin
        found = 1'b1;
        foundIdx = SW'(i);
      end
      if (!s.macValid[i]) begin
        haveFree = 1'b1;
        freeIdx = SW'(i); // Lowest free slot wins, so admission is in arrival order.
      end
      learned = learned + 8'(s.macValid[i]);
    end
    capOn = s.limitEn && (s.cap != 7'h00);
  end

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    logic [7:0] a;
    logic canLearn;
    logic pass;
    a = s.wrAddr;
    canLearn = 1'b0;
    pass = 1'b0;
    next_s = s;
    entry = ruleMem[(s.scanIdx >= 8'd1 && s.scanIdx <= 8'(GC)) ? s.scanIdx : 8'd1];
    hitNow = s.ruleValid[(s.scanIdx >= 8'd1 && s.scanIdx <= 8'(GC)) ? s.scanIdx : 8'd1] &&
      ruleMatch(entry, s);
    ruleWr = 1'b0;
    ruleWrIdx = s.ruleGroupIndex;
    macWr = 1'b0;
    macWrIdx = freeIdx;
    next_s.verdictValid = 1'b0;
    next_s.hreadyout = 1'b1;
    // Reads are decoded in the address phase, so data is ready with zero waits.
    if (hsel && htrans[1] && hready) begin
      next_s.wrPend = hwrite;
      next_s.wrAddr = haddr[7:0];
      unique case (haddr[7:0])
        ingress_acl_filter_pkg::OFF_GLOBAL: next_s.hrdata = {30'h0, s.limitEn, s.bindEn};
        ingress_acl_filter_pkg::OFF_DSCP_EN: next_s.hrdata = 32'(s.dscpEn);
        ingress_acl_filter_pkg::OFF_ADDR_CAP: next_s.hrdata = 32'(s.cap);
        ingress_acl_filter_pkg::OFF_INDEX: next_s.hrdata = 32'(s.ruleGroupIndex);
        ingress_acl_filter_pkg::OFF_CTRL: next_s.hrdata = {4'h0, s.stage.vid, 5'h00,
          s.stage.valueAny, s.stage.protoAny, s.stage.fragVal, s.stage.fragChk,
          s.stage.dstAny, s.stage.srcAny, s.stage.vlanAny, s.stage.kind, 1'b0, s.stage.deny};
        ingress_acl_filter_pkg::OFF_SRC_IP: next_s.hrdata = s.stage.srcIp;
        ingress_acl_filter_pkg::OFF_SRC_MASK: next_s.hrdata = s.stage.srcMask;
        ingress_acl_filter_pkg::OFF_DST_IP: next_s.hrdata = s.stage.dstIp;
        ingress_acl_filter_pkg::OFF_DST_MASK: next_s.hrdata = s.stage.dstMask;
        ingress_acl_filter_pkg::OFF_PARAM: next_s.hrdata = {11'h0, s.stage.bindPort, 3'h0,
          s.stage.portSel, s.stage.proto};
        ingress_acl_filter_pkg::OFF_VALUE: next_s.hrdata = 32'(s.stage.value);
        ingress_acl_filter_pkg::OFF_MAC_HI: next_s.hrdata = 32'(s.stage.mac[47:32]);
        ingress_acl_filter_pkg::OFF_MAC_LO: next_s.hrdata = s.stage.mac[31:0];
        ingress_acl_filter_pkg::OFF_STATUS: next_s.hrdata = {s.blockedCount, 7'h00,
          (s.st != ingress_acl_filter_pkg::ST_IDLE), learned};
        default: next_s.hrdata = 32'h00000000;
      endcase
    end else begin
      next_s.wrPend = 1'b0;
    end
    // Write data phase.
    if (s.wrPend) begin
      unique case (a)
        ingress_acl_filter_pkg::OFF_GLOBAL: begin
          next_s.bindEn = hwdata[ingress_acl_filter_pkg::GLB_BIND_EN];
          next_s.limitEn = hwdata[ingress_acl_filter_pkg::GLB_LIMIT_EN];
        end
        ingress_acl_filter_pkg::OFF_DSCP_EN: next_s.dscpEn = hwdata[PC-1:0];
        ingress_acl_filter_pkg::OFF_ADDR_CAP: next_s.cap = hwdata[6:0];
        ingress_acl_filter_pkg::OFF_INDEX: next_s.ruleGroupIndex = hwdata[7:0];
        ingress_acl_filter_pkg::OFF_COMMIT: begin
          // Group numbers outside 1..247 are silently ignored.
          if (s.ruleGroupIndex >= 8'd1 && s.ruleGroupIndex <= 8'(GC)) begin
            if (hwdata[ingress_acl_filter_pkg::CMT_CLEAR]) begin
              next_s.ruleValid[s.ruleGroupIndex] = 1'b0;
            end else if (hwdata[ingress_acl_filter_pkg::CMT_STORE]) begin
              ruleWr = 1'b1;
              next_s.ruleValid[s.ruleGroupIndex] = 1'b1;
              next_s.stage = ingress_acl_filter_pkg::STAGE_DEFAULT;
            end
          end
        end
        ingress_acl_filter_pkg::OFF_CTRL: begin
          next_s.stage.deny = hwdata[ingress_acl_filter_pkg::CTL_DENY];
          next_s.stage.kind = ingress_acl_filter_pkg::kind_type'(
            hwdata[ingress_acl_filter_pkg::CTL_KIND +: 2]);
          next_s.stage.vlanAny = hwdata[ingress_acl_filter_pkg::CTL_VLAN_ANY];
          next_s.stage.srcAny = hwdata[ingress_acl_filter_pkg::CTL_SRC_ANY];
          next_s.stage.dstAny = hwdata[ingress_acl_filter_pkg::CTL_DST_ANY];
          next_s.stage.fragChk = hwdata[ingress_acl_filter_pkg::CTL_FRAG_CHK];
          next_s.stage.fragVal = hwdata[ingress_acl_filter_pkg::CTL_FRAG_VAL];
          next_s.stage.protoAny = hwdata[ingress_acl_filter_pkg::CTL_PROTO_ANY];
          next_s.stage.valueAny = hwdata[ingress_acl_filter_pkg::CTL_VALUE_ANY];
          next_s.stage.vid = hwdata[ingress_acl_filter_pkg::CTL_VID +: 12];
        end
        ingress_acl_filter_pkg::OFF_SRC_IP: next_s.stage.srcIp = hwdata;
        ingress_acl_filter_pkg::OFF_SRC_MASK: next_s.stage.srcMask = hwdata;
        ingress_acl_filter_pkg::OFF_DST_IP: next_s.stage.dstIp = hwdata;
        ingress_acl_filter_pkg::OFF_DST_MASK: next_s.stage.dstMask = hwdata;
        ingress_acl_filter_pkg::OFF_PARAM: begin
          next_s.stage.proto = hwdata[7:0];
          next_s.stage.portSel = hwdata[ingress_acl_filter_pkg::PRM_PORT_SEL +: 5];
          next_s.stage.bindPort = hwdata[ingress_acl_filter_pkg::PRM_BIND_PORT +: 5];
        end
        ingress_acl_filter_pkg::OFF_VALUE: next_s.stage.value = hwdata[15:0];
        ingress_acl_filter_pkg::OFF_MAC_HI: next_s.stage.mac[47:32] = hwdata[15:0];
        ingress_acl_filter_pkg::OFF_MAC_LO: next_s.stage.mac[31:0] = hwdata;
        default: begin
        end
      endcase
    end
    // Frame pipeline: a linear scan keeps the table in plain memory at one
    // group per cycle, trading latency for area.
    unique case (s.st)
      ingress_acl_filter_pkg::ST_IDLE: begin
        if (frmValid) begin
          next_s.port = frmPort;
          next_s.vlan = frmVlan;
          next_s.ipv4 = frmIpv4;
          next_s.etherType = frmEtherType;
          next_s.srcIp = frmSrcIp;
          next_s.dstIp = frmDstIp;
          next_s.frag = frmFrag;
          next_s.proto = frmProto;
          next_s.l4Port = frmL4Port;
          next_s.srcMac = frmSrcMac;
          next_s.scanIdx = 8'd1;
          next_s.frmReady = 1'b0;
          next_s.st = ingress_acl_filter_pkg::ST_SCAN;
        end
      end
      ingress_acl_filter_pkg::ST_SCAN: begin
        if (hitNow) begin
          next_s.aclHit = 1'b1;
          next_s.aclDeny = entry.deny;
          next_s.st = ingress_acl_filter_pkg::ST_CHECK;
        end else if (s.scanIdx == 8'(GC)) begin
          next_s.aclHit = 1'b0;
          next_s.aclDeny = 1'b0;
          next_s.st = ingress_acl_filter_pkg::ST_CHECK;
        end else begin
          next_s.scanIdx = s.scanIdx + 8'd1;
        end
      end
      ingress_acl_filter_pkg::ST_CHECK: begin
        canLearn = !found && haveFree && (!capOn || (learned < 8'(s.cap)));
        if (found) begin
          next_s.macHit[foundIdx] = 1'b1;
        end
        if (canLearn) begin
          macWr = 1'b1;
          next_s.macValid[freeIdx] = 1'b1;
          next_s.macHit[freeIdx] = 1'b1;
        end
        next_s.macBlocked = capOn && !found && !canLearn;
        pass = !(s.aclHit && s.aclDeny) && !next_s.macBlocked;
        if (!pass) begin
          next_s.blockedCount = s.blockedCount + 16'h0001;
        end
        next_s.verdictPass = pass;
        next_s.verdictMapDscp = s.ipv4 && (s.port != 5'h00) && (s.port <= 5'(PC)) &&
          s.dscpEn[(s.port != 5'h00) ? s.port - 5'h01 : 5'h00];
        next_s.verdictValid = 1'b1;
        next_s.frmReady = 1'b1;
        next_s.st = ingress_acl_filter_pkg::ST_IDLE;
      end
      default: begin
        next_s.st = ingress_acl_filter_pkg::ST_IDLE;
      end
    endcase
    // Ageing sweep: a slot not seen since the last sweep is freed. A hit in the
    // sweep cycle has already been folded into next_s.macHit, so it survives.
    if (s.ageCnt >= AGE_CYCLES - 32'h00000001) begin
      next_s.ageCnt = 32'h00000000;
      next_s.macValid = next_s.macValid & next_s.macHit;
      next_s.macHit = '0;
    end else begin
      next_s.ageCnt = s.ageCnt + 32'h00000001;
    end
  end

  // ******************************************************************
  // Registers and memories
  // ******************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.hreadyout <= 1'b1;
      s.frmReady <= 1'b1;
      s.st <= ingress_acl_filter_pkg::ST_IDLE;
      s.stage <= ingress_acl_filter_pkg::STAGE_DEFAULT;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ruleWr) begin
      ruleMem[ruleWrIdx] <= s.stage;
    end
    if (macWr) begin
      macMem[macWrIdx] <= s.srcMac;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign frmReady = s.frmReady;
  assign verdictValid = s.verdictValid;
  assign verdictPass = s.verdictPass;
  assign verdictMapDscp = s.verdictMapDscp;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_scan_index_range: assert property (
    s.st == ingress_acl_filter_pkg::ST_SCAN |-> s.scanIdx >= 8'd1 && s.scanIdx <= 8'd247)
    else $error("Scan index left the group range.");
  a_verdict_bounded: assert property (
    frmValid && frmReady |-> ##[2:249] verdictValid)
    else $error("Frame verdict did not arrive within the scan bound.");
  a_first_match_stops: assert property (
    s.st == ingress_acl_filter_pkg::ST_SCAN && hitNow |=> s.st == ingress_acl_filter_pkg::ST_CHECK
      ##1 verdictValid)
    else $error("Scan did not stop at the first matching group.");
  a_deny_drops: assert property (
    s.st == ingress_acl_filter_pkg::ST_CHECK && s.aclHit && s.aclDeny |=> verdictValid &&
      !verdictPass)
    else $error("Denied frame was passed.");
  a_unmatched_pass: assert property (
    s.st == ingress_acl_filter_pkg::ST_CHECK && !s.aclHit && !capOn |=> verdictPass)
    else $error("Unmatched frame without address cap was dropped.");
  a_binding_gated: assert property (
    s.st == ingress_acl_filter_pkg::ST_SCAN && !s.bindEn &&
      entry.kind == ingress_acl_filter_pkg::KIND_BINDING |-> !hitNow)
    else $error("Binding group matched with binding disabled.");
  a_cap_held: assert property (
    capOn && learned <= 8'(s.cap) && $stable(s.cap) |=> learned <= 8'($past(s.cap)))
    else $error("Address table grew beyond the cap.");
  a_absent_blocked: assert property (
    s.st == ingress_acl_filter_pkg::ST_CHECK && capOn && !found &&
      (!haveFree || learned >= 8'(s.cap)) |=> verdictValid && !verdictPass)
    else $error("Frame from an unstored source passed under the cap.");
  a_dscp_follows: assert property (
    verdictValid |-> verdictMapDscp == (s.ipv4 && s.port >= 5'd1 && s.port <= 5'd26 &&
      $past(s.dscpEn[(s.port != 5'h00) ? s.port - 5'h01 : 5'h00])))
    else $error("DSCP map flag disagrees with the port enable.");
endmodule
`default_nettype wire

// >>> ingress_acl_filter_pkg.sv
// Constants, register map and types shared by the ingress access filter.
`default_nettype none
package ingress_acl_filter_pkg;
  // ********************************************************************
  // Sizes and timing
  // ********************************************************************
  localparam int PORT_COUNT = 26;
  localparam int GROUP_COUNT = 247;
  localparam int ADDR_SLOTS = 64;
  localparam longint CLK_HZ = 10_000_000;
  localparam longint AGE_SECONDS = 300;
  // ********************************************************************
  // Register byte offsets
  // ********************************************************************
  localparam logic [7:0] OFF_GLOBAL = 8'h00;
  localparam logic [7:0] OFF_DSCP_EN = 8'h04;
  localparam logic [7:0] OFF_ADDR_CAP = 8'h08;
  localparam logic [7:0] OFF_INDEX = 8'h0c;
  localparam logic [7:0] OFF_COMMIT = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_SRC_IP = 8'h18;
  localparam logic [7:0] OFF_SRC_MASK = 8'h1c;
  localparam logic [7:0] OFF_DST_IP = 8'h20;
  localparam logic [7:0] OFF_DST_MASK = 8'h24;
  localparam logic [7:0] OFF_PARAM = 8'h28;
  localparam logic [7:0] OFF_VALUE = 8'h2c;
  localparam logic [7:0] OFF_MAC_HI = 8'h30;
  localparam logic [7:0] OFF_MAC_LO = 8'h34;
  localparam logic [7:0] OFF_STATUS = 8'h38;
  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int GLB_BIND_EN = 0;
  localparam int GLB_LIMIT_EN = 1;
  localparam int CMT_STORE = 0;
  localparam int CMT_CLEAR = 1;
  localparam int CTL_DENY = 0;
  localparam int CTL_KIND = 2;
  localparam int CTL_VLAN_ANY = 4;
  localparam int CTL_SRC_ANY = 5;
  localparam int CTL_DST_ANY = 6;
  localparam int CTL_FRAG_CHK = 7;
  localparam int CTL_FRAG_VAL = 8;
  localparam int CTL_PROTO_ANY = 9;
  localparam int CTL_VALUE_ANY = 10;
  localparam int CTL_VID = 16;
  localparam int PRM_PORT_SEL = 8;
  localparam int PRM_BIND_PORT = 16;
  localparam int STS_BUSY = 8;
  localparam int STS_BLOCKED = 16;
  // ********************************************************************
  // Types and reset values
  // ********************************************************************
  typedef enum logic [1:0] {
    KIND_IPV4 = 2'b00,
    KIND_NON_IPV4 = 2'b01,
    KIND_BINDING = 2'b10
  } kind_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SCAN = 2'b01,
    ST_CHECK = 2'b10
  } state_type;
  typedef struct packed {
    logic deny;
    kind_type kind;
    logic vlanAny;
    logic [11:0] vid;
    logic srcAny;
    logic [31:0] srcIp;
    logic [31:0] srcMask;
    logic dstAny;
    logic [31:0] dstIp;
    logic [31:0] dstMask;
    logic fragChk;
    logic fragVal;
    logic protoAny;
    logic [7:0] proto;
    logic valueAny;
    logic [15:0] value;
    logic [4:0] portSel;
    logic [4:0] bindPort;
    logic [47:0] mac;
  } rule_entry_type;
  localparam logic [47:0] MAC_DEFAULT = 48'h001122334455;
  localparam logic [4:0] BIND_PORT_DEFAULT = 5'h01;
  localparam rule_entry_type STAGE_DEFAULT = '{
    deny: 1'b0, kind: KIND_IPV4, vlanAny: 1'b1, vid: 12'h000, srcAny: 1'b1,
    srcIp: 32'h00000000, srcMask: 32'hffffffff, dstAny: 1'b1,
    dstIp: 32'h00000000, dstMask: 32'hffffffff, fragChk: 1'b0, fragVal: 1'b0,
    protoAny: 1'b1, proto: 8'h00, valueAny: 1'b1, value: 16'h0000,
    portSel: 5'h00, bindPort: BIND_PORT_DEFAULT, mac: MAC_DEFAULT};
endpackage
`default_nettype wire

// >>> frame_source.sv
// Frame source model standing in for the switch ingress port logic.
`default_nettype none
module frame_source (
  // Clock and handshake
  input wire logic core_clk,
  input wire logic frmReady,
  output logic frmValid,
  // Frame fields
  output logic [4:0] frmPort,
  output logic [11:0] frmVlan,
  output logic frmIpv4,
  output logic [15:0] frmEtherType,
  output logic [31:0] frmSrcIp,
  output logic [31:0] frmDstIp,
  output logic frmFrag,
  output logic [7:0] frmProto,
  output logic [15:0] frmL4Port,
  output logic [47:0] frmSrcMac
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [170:0] fields = '0;
  assign {frmPort, frmVlan, frmIpv4, frmEtherType, frmSrcIp, frmDstIp, frmFrag, frmProto,
    frmL4Port, frmSrcMac} = fields;
  initial frmValid = 1'b0;
  // Fields are inverted once taken, so nothing can lean on stale values.
  task automatic send(input logic [4:0] p, input logic [11:0] v, input logic ip4,
      input logic [15:0] et, input logic [31:0] sip, input logic [7:0] pr,
      input logic [15:0] l4, input logic [47:0] mac);
    @(posedge core_clk);
    frmValid <= 1'b1;
    fields <= {p, v, ip4, et, sip, 32'h0a000001, 1'b0, pr, l4, mac};
    do @(negedge core_clk); while (frmReady !== 1'b1);
    @(posedge core_clk);
    frmValid <= 1'b0;
    fields <= ~fields;
  endtask
endmodule
`default_nettype wire

// >>> tb_ingress_acl_filter.sv
// Self-checking testbench for the ingress access filter.
`default_nettype none
module tb_ingress_acl_filter;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, frmValid, frmReady, verdictValid, verdictPass, verdictMapDscp;
  logic [4:0] frmPort;
  logic [11:0] frmVlan;
  logic frmIpv4, frmFrag;
  logic [15:0] frmEtherType, frmL4Port;
  logic [31:0] frmSrcIp, frmDstIp;
  logic [7:0] frmProto;
  logic [47:0] frmSrcMac;
  int bad_count = 0, total_checks = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  ingress_acl_filter #(.AGE_CYCLES(32'd800)) ingress_acl_filter_i (.core_clk, .sys_rst, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout, .hresp,
    .hrdata, .frmValid, .frmPort, .frmVlan, .frmIpv4, .frmEtherType, .frmSrcIp, .frmDstIp,
    .frmFrag, .frmProto, .frmL4Port, .frmSrcMac, .frmReady, .verdictValid, .verdictPass,
    .verdictMapDscp);
  frame_source frame_source_i (.core_clk, .frmReady, .frmValid, .frmPort, .frmVlan, .frmIpv4,
    .frmEtherType, .frmSrcIp, .frmDstIp, .frmFrag, .frmProto, .frmL4Port, .frmSrcMac);
  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    @(posedge core_clk);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(negedge core_clk); while (hreadyout !== 1'b1);
    @(posedge core_clk);
    q = hrdata;
  endtask
  task automatic fr(input logic [4:0] p, input logic [11:0] v, input logic ip4,
      input logic [15:0] et, input logic [31:0] sip, input logic [7:0] pr,
      input logic [15:0] l4, input logic [47:0] mac, input logic ps, input logic mp);
    frame_source_i.send(p, v, ip4, et, sip, pr, l4, mac);
    do @(negedge core_clk); while (verdictValid !== 1'b1);
    check({30'h0, verdictPass, verdictMapDscp}, {30'h0, ps, mp});
  endtask
  // A full scan takes about 250 cycles, so the sweep period must span several frames.
  task automatic rst();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask
  // A group is staged field by field, then stored under its number.
  task automatic grp(input logic [7:0] n, input logic [31:0] c, input logic [31:0] pm,
      input logic [31:0] v);
    bus(1'b1, ingress_acl_filter_pkg::OFF_CTRL, c);
    bus(1'b1, ingress_acl_filter_pkg::OFF_PARAM, pm);
    bus(1'b1, ingress_acl_filter_pkg::OFF_VALUE, v);
    bus(1'b1, ingress_acl_filter_pkg::OFF_INDEX, {24'h0, n});
    bus(1'b1, ingress_acl_filter_pkg::OFF_COMMIT, 32'h1);
  endtask
  // ********************************************************************
  // Tests
  // ********************************************************************
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    rst();
    bus(1'b0, ingress_acl_filter_pkg::OFF_CTRL, 32'h0);
    check(q, 32'h00000670);
    bus(1'b1, ingress_acl_filter_pkg::OFF_DSCP_EN, 32'h4);
    fr(5'd3, 12'd1, 1'b1, 16'h0800, 32'h01020304, 8'd6, 16'd80, 48'h1, 1'b1, 1'b1);
    fr(5'd4, 12'd1, 1'b1, 16'h0800, 32'h01020304, 8'd6, 16'd80, 48'h1, 1'b1, 1'b0);
    $display("dscp test done");
    bus(1'b1, ingress_acl_filter_pkg::OFF_SRC_IP, 32'hc0a80000);
    bus(1'b1, ingress_acl_filter_pkg::OFF_SRC_MASK, 32'hffff0000);
    grp(8'd5, 32'h51, 32'h6, 32'd80);
    fr(5'd2, 12'd1, 1'b1, 16'h0800, 32'hc0a81234, 8'd6, 16'd80, 48'h2, 1'b0, 1'b0);
    fr(5'd2, 12'd1, 1'b1, 16'h0800, 32'hc0a90000, 8'd6, 16'd80, 48'h2, 1'b1, 1'b0);
    fr(5'd2, 12'd1, 1'b1, 16'h0800, 32'hc0a81234, 8'd17, 16'd80, 48'h2, 1'b1, 1'b0);
    fr(5'd2, 12'd1, 1'b1, 16'h0800, 32'hc0a81234, 8'd6, 16'd81, 48'h2, 1'b1, 1'b0);
    fr(5'd2, 12'd1, 1'b0, 16'h0800, 32'hc0a81234, 8'd6, 16'd80, 48'h2, 1'b1, 1'b0);
    grp(8'd2, 32'h15, 32'h0, 32'h0806);
    grp(8'd1, 32'h670, 32'h0700, 32'h0);
    fr(5'd9, 12'd1, 1'b0, 16'h0806, 32'h0, 8'd0, 16'd0, 48'h3, 1'b0, 1'b0);
    fr(5'd9, 12'd1, 1'b0, 16'h8137, 32'h0, 8'd0, 16'd0, 48'h3, 1'b1, 1'b0);
    fr(5'd7, 12'd1, 1'b1, 16'h0800, 32'hc0a81234, 8'd6, 16'd80, 48'h4, 1'b1, 1'b0);
    fr(5'd8, 12'd1, 1'b1, 16'h0800, 32'hc0a81234, 8'd6, 16'd80, 48'h4, 1'b0, 1'b0);
    $display("rule group test done");
    grp(8'd3, 32'h000a0009, 32'h00010000, 32'h0);
    fr(5'd1, 12'd10, 1'b1, 16'h0800, 32'h0, 8'd17, 16'd0, 48'h1122334455, 1'b1, 1'b0);
    bus(1'b1, ingress_acl_filter_pkg::OFF_GLOBAL, 32'h1);
    fr(5'd1, 12'd10, 1'b1, 16'h0800, 32'h0, 8'd17, 16'd0, 48'h1122334455, 1'b0, 1'b0);
    fr(5'd1, 12'd11, 1'b1, 16'h0800, 32'h0, 8'd17, 16'd0, 48'h1122334455, 1'b1, 1'b0);
    grp(8'd4, 32'h001406e1, 32'h0, 32'h0);
    fr(5'd12, 12'd20, 1'b1, 16'h0800, 32'h0, 8'd6, 16'd80, 48'h5, 1'b0, 1'b0);
    fr(5'd12, 12'd21, 1'b1, 16'h0800, 32'h0, 8'd6, 16'd80, 48'h5, 1'b1, 1'b0);
    $display("binding test done");
    rst();
    bus(1'b1, ingress_acl_filter_pkg::OFF_ADDR_CAP, 32'h2);
    bus(1'b1, ingress_acl_filter_pkg::OFF_GLOBAL, 32'h2);
    fr(5'd1, 12'd1, 1'b0, 16'h1234, 32'h0, 8'd0, 16'd0, 48'ha1, 1'b1, 1'b0);
    fr(5'd1, 12'd1, 1'b0, 16'h1234, 32'h0, 8'd0, 16'd0, 48'ha2, 1'b1, 1'b0);
    fr(5'd1, 12'd1, 1'b0, 16'h1234, 32'h0, 8'd0, 16'd0, 48'ha3, 1'b0, 1'b0);
    fr(5'd1, 12'd1, 1'b0, 16'h1234, 32'h0, 8'd0, 16'd0, 48'ha1, 1'b1, 1'b0);
    bus(1'b0, ingress_acl_filter_pkg::OFF_STATUS, 32'h0);
    check(q, 32'h00010002);
    repeat (500) @(posedge core_clk);
    fr(5'd1, 12'd1, 1'b0, 16'h1234, 32'h0, 8'd0, 16'd0, 48'ha3, 1'b1, 1'b0);
    $display("address cap test done");
    end_sim();
  end
endmodule
`default_nettype wire
